/* File: verilog/motion_event_monitor.sv */
// motion event monitor core: debounce, flags, alert, logs, command engine
`timescale 1ns/1ps
`include "motion_event_monitor_cfg.svh"
module motion_event_monitor
    import motion_event_monitor_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `MS_PERIOD_NS / `CLK_PERIOD_NS
)(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        LINK_CLK,
    input  wire logic        LINK_RESET_N,
    input  wire logic        MOTION_IN,
    input  wire logic        ADDR_STRAP_OPEN,
    input  wire logic        ALERT_I,
    output logic             ALERT_O,
    output logic             ALERT_OE_N,
    output logic             RAW_MOTION_LEVEL,
    output logic             ARRIVAL_FLAG,
    output logic             DEPARTURE_FLAG,
    output logic             EVENT_PENDING_FLAG,
    input  wire logic        LINK_REQ,
    input  wire logic [6:0]  LINK_DEV_ADDR,
    input  wire logic [4:0]  LINK_CMD,
    input  wire logic [15:0] LINK_WDATA,
    output logic             LINK_BUSY,
    output logic             LINK_DONE,
    output logic             LINK_ACK,
    output logic [31:0]      LINK_RDATA
);

    localparam logic [`PRESCALE_W-1:0] MS_LAST =
        `PRESCALE_W'(MS_CYCLES - 1);
    localparam logic [3:0] LOG_FULL = 4'(`LOG_DEPTH);

    core_s       s;
    core_s       next_s;
    logic [1:0]  evt;
    logic [1:0]  pop;
    logic [1:0]  push;
    logic        exec;
    logic        hit;
    logic        tick;
    logic        sel;
    cmd_e        cmd;
    logic        req_tgl;
    logic [6:0]  hold_addr;
    logic [4:0]  hold_cmd;
    logic [15:0] hold_wdata;

    // ==========================================================
    // circular index wrap for the ten-entry logs
    function automatic logic [3:0] wrap(input logic [4:0] a);
        if (a >= 5'(`LOG_DEPTH)) begin
            return 4'(a - 5'(`LOG_DEPTH));
        end
        return a[3:0];
    endfunction

    // ==========================================================
    // link side, on its own clock
    link_port link (
        .link_clk      (LINK_CLK),
        .link_reset_n  (LINK_RESET_N),
        .link_req      (LINK_REQ),
        .link_dev_addr (LINK_DEV_ADDR),
        .link_cmd      (LINK_CMD),
        .link_wdata    (LINK_WDATA),
        .link_busy     (LINK_BUSY),
        .link_done     (LINK_DONE),
        .link_ack      (LINK_ACK),
        .link_rdata    (LINK_RDATA),
        .req_tgl       (req_tgl),
        .hold_addr     (hold_addr),
        .hold_cmd      (hold_cmd),
        .hold_wdata    (hold_wdata),
        .ack_tgl       (s.ack_tgl),
        .core_ack      (s.ack),
        .core_rdata    (s.rdata)
    );

    // ==========================================================
    // whole core state computed in one place
    always_comb begin
        next_s = s;
        evt = '0;
        pop = '0;
        push = '0;
        cmd = cmd_e'(hold_cmd);
        hit = (hold_addr == s.bus_addr);
        exec = s.req_sync[1] ^ s.req_sync[2];
        sel = (cmd == departure_log_status) || (cmd == departure_log_age)
           || (cmd == departure_log_pop) || (cmd == departure_since_last);

        // pins and the request toggle pass three flops
        next_s.motion_sync = {s.motion_sync[1:0], MOTION_IN};
        next_s.strap_sync = {s.strap_sync[1:0], ADDR_STRAP_OPEN};
        next_s.alert_sync = {s.alert_sync[1:0], ALERT_I};
        next_s.req_sync = {s.req_sync[1:0], req_tgl};
        if (s.motion_sync[1] == s.motion_sync[2]) begin
            next_s.raw = s.motion_sync[2];
        end

        // millisecond time base, free running
        tick = (s.prescale == MS_LAST);
        next_s.prescale = tick ? '0 : s.prescale + 1'b1;
        if (tick) begin
            next_s.ms_now = s.ms_now + 32'd1;
        end

        // strap caught after release, once the sync holds the pin
        if (s.strap_cnt != `STRAP_CYCLES) begin
            next_s.strap_cnt = s.strap_cnt + 3'd1;
            if (s.strap_sync[1] == s.strap_sync[2]) begin
                next_s.bus_addr = s.strap_sync[2] ?
                    `ADDR_STRAP_OPEN : `ADDR_STRAP_CLOSED;
            end
        end

        // debounce: a level change must hold for the settle time
        // resolution is one millisecond tick, so a change may count
        // up to one tick before the full settle time has passed
        if (s.raw == s.deb) begin
            next_s.settle_cnt = '0;
        end else if (s.settle_cnt >= s.settle) begin
            next_s.deb = s.raw;
            next_s.settle_cnt = '0;
            evt[0] = s.raw;
            evt[1] = !s.raw;
        end else if (tick) begin
            next_s.settle_cnt = s.settle_cnt + 16'd1;
        end

        // command engine, one command per request toggle
        if (exec) begin
            next_s.ack_tgl = ~s.ack_tgl;
            next_s.ack = hit;
            next_s.rdata = '0;
            if (hit) begin
                case (cmd)
                    part_id_read: begin
                        next_s.rdata = {24'h0, `PART_ID};
                    end
                    firmware_revision_read: begin
                        next_s.rdata =
                            {16'h0, `FW_MAJOR, `FW_MINOR};
                    end
                    status_read: begin
                        next_s.rdata = {26'h0, s.alert_sync[2],
                            s.alert_en, s.raw, s.pending,
                            s.departure, s.arrival};
                    end
                    clear_event_flags: begin
                        next_s.arrival = 1'b0;
                        next_s.departure = 1'b0;
                        next_s.pending = 1'b0;
                        next_s.alert_oe_n = 1'b1;
                    end
                    settle_time_write: begin
                        next_s.settle = hold_wdata;
                    end
                    settle_time_read: begin
                        next_s.rdata = {16'h0, s.settle};
                    end
                    alert_on: begin
                        next_s.alert_en = 1'b1;
                    end
                    alert_off: begin
                        next_s.alert_en = 1'b0;
                    end
                    alert_config_default: begin
                        next_s.alert_en = 1'b0;
                    end
                    bus_address_write: begin
                        next_s.bus_addr = hold_wdata[6:0];
                    end
                    bus_address_read: begin
                        next_s.rdata = {25'h0, s.bus_addr};
                    end
                    arrival_log_status, departure_log_status: begin
                        next_s.rdata = {30'h0,
                            s.cnt[sel] == LOG_FULL,
                            s.cnt[sel] == 4'd0};
                    end
                    arrival_log_age, departure_log_age: begin
                        if (s.cnt[sel] != 4'd0) begin
                            next_s.rdata = s.ms_now
                                - s.mem[sel][s.head[sel]];
                        end
                    end
                    arrival_log_pop, departure_log_pop: begin
                        if (s.cnt[sel] != 4'd0) begin
                            pop[sel] = 1'b1;
                            next_s.rdata = s.mem[sel][s.head[sel]];
                        end
                    end
                    arrival_since_last, departure_since_last: begin
                        next_s.rdata = s.ms_now - s.last[sel];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // logs: push the event time, a full log drops it
        for (int i = 0; i < 2; i++) begin
            push[i] = evt[i] && (s.cnt[i] != LOG_FULL);
            if (push[i]) begin
                next_s.mem[i][wrap({1'b0, s.head[i]} + {1'b0, s.cnt[i]})]
                    = s.ms_now;
            end
            if (pop[i]) begin
                next_s.head[i] = wrap({1'b0, s.head[i]} + 5'd1);
            end
            next_s.cnt[i] = s.cnt[i] + {3'b0, push[i]} - {3'b0, pop[i]};
            if (evt[i]) begin
                next_s.last[i] = s.ms_now;
            end
        end

        // events set after the clear, so a same-cycle event survives
        if (evt[0]) begin
            next_s.arrival = 1'b1;
        end
        if (evt[1]) begin
            next_s.departure = 1'b1;
        end
        if (|evt) begin
            next_s.pending = 1'b1;
            if (next_s.alert_en) begin
                next_s.alert_oe_n = 1'b0;
            end
        end
        if (!next_s.alert_en) begin
            next_s.alert_oe_n = 1'b1;
        end

        // synchronous reset values
        if (!RESET_N) begin
            next_s = '0;
            next_s.settle = `SETTLE_RESET_MS;
            next_s.alert_oe_n = 1'b1;
            next_s.bus_addr = `ADDR_STRAP_CLOSED;
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    // ==========================================================
    // outputs straight from state; the pin only ever pulls low
    assign ALERT_O            = 1'b0;
    assign ALERT_OE_N         = s.alert_oe_n;
    assign RAW_MOTION_LEVEL   = s.raw;
    assign ARRIVAL_FLAG       = s.arrival;
    assign DEPARTURE_FLAG     = s.departure;
    assign EVENT_PENDING_FLAG = s.pending;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    a_raw_follow: assert property (
        (s.motion_sync[1] == s.motion_sync[2])
        |=> (RAW_MOTION_LEVEL == $past(s.motion_sync[2])))
        else $error("raw level does not follow settled pin");

    a_arrival_set: assert property (
        evt[0] |=> (ARRIVAL_FLAG && EVENT_PENDING_FLAG))
        else $error("arrival event did not set flags");

    a_arrival_settled: assert property (
        evt[0] |-> (s.raw && !s.deb && s.settle_cnt >= s.settle))
        else $error("arrival before settle time");

    a_departure_set: assert property (
        evt[1] |=> (DEPARTURE_FLAG && EVENT_PENDING_FLAG))
        else $error("departure event did not set flags");

    a_settle_default: assert property (
        $rose(RESET_N) |-> (s.settle == `SETTLE_RESET_MS))
        else $error("settle time not 750 after reset");

    a_alert_disabled: assert property (
        !s.alert_en |-> ALERT_OE_N)
        else $error("alert driven while disabled");

    a_alert_on_event: assert property (
        (|evt) |=> (!s.alert_en || !ALERT_OE_N))
        else $error("enabled alert not driven on event");

    a_clear_flags: assert property (
        (exec && hit && cmd == clear_event_flags && !(|evt))
        |=> (!ARRIVAL_FLAG && !DEPARTURE_FLAG && !EVENT_PENDING_FLAG))
        else $error("clear left a flag set");

    a_clear_release: assert property (
        (exec && hit && cmd == clear_event_flags && !(|evt))
        |=> ALERT_OE_N)
        else $error("clear did not release alert");

    a_default_off: assert property (
        (exec && hit && cmd == alert_config_default)
        |=> (!s.alert_en [*2]))
        else $error("alert default left alerts on");

    a_log_bound: assert property (
        (s.cnt[0] <= LOG_FULL) && (s.cnt[1] <= LOG_FULL))
        else $error("log count above ten");

    a_pop_shrinks: assert property (
        (pop[0] && !push[0]) |=> (s.cnt[0] == $past(s.cnt[0]) - 4'd1))
        else $error("pop did not remove an entry");

    a_full_keeps: assert property (
        (evt[1] && s.cnt[1] == LOG_FULL && !pop[1])
        |=> (s.cnt[1] == LOG_FULL && $stable(s.mem[1])))
        else $error("full log changed on event");

    a_id_answer: assert property (
        (exec && hit && cmd == part_id_read)
        |=> (s.ack && s.rdata == {24'h0, `PART_ID}))
        else $error("wrong identification answer");

    a_miss_silent: assert property (
        (exec && !hit) |=> !s.ack)
        else $error("acknowledged a foreign address");

    a_addr_write: assert property (
        (exec && hit && cmd == bus_address_write)
        |=> (s.bus_addr == hold_wdata[6:0]))
        else $error("written bus address not taken");

    c_arrival: cover property (evt[0] ##[1:400] evt[1]);
    c_full_drop: cover property (evt[0] && s.cnt[0] == LOG_FULL);
    c_pop: cover property (pop[1]);
    c_clear: cover property (exec && hit && cmd == clear_event_flags);
    c_strap_open: cover property (s.bus_addr == `ADDR_STRAP_OPEN);

endmodule

/* File: verilog/motion_event_monitor_cfg.svh */
// constants of the motion event monitor: timing, addresses, reset values
// What this block does
// - host reads the raw, undebounced motion sensor level, one while motion
// - arrival flag sets after sensor goes active and stays so for settle time
// - departure flag sets after sensor goes inactive and stays so for settle
// - settle time in milliseconds, host writable and readable, resets to 750
// - alert pin asserts on each debounced event only while alerts enabled
// - clear command zeroes arrival, departure and pending flags together
// - clearing the event flags releases the alert pin high
// - alert default command restores alert settings, alerts disabled
// - arrival log keeps up to ten timestamps, reports full and empty
// - host reads oldest arrival entry age; pop returns and removes it
// - departure log keeps up to ten timestamps, reports full and empty
// - host reads oldest departure entry age; pop returns and removes it
// - report milliseconds since latest arrival and since latest departure
// - a fixed 8-bit identification code is readable by the host
// - 16-bit firmware revision, major in upper byte, minor in lower byte
// - host writes new bus address, used next on bus, readable back
// - acknowledge transfers sent to the current bus address
// - alert pin is active low, open drain, pulled high externally
// - bus address defaults to 0x12, 0x13 when address strap is open
`ifndef MOTION_EVENT_MONITOR_CFG_SVH
`define MOTION_EVENT_MONITOR_CFG_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS     10
`define MS_PERIOD_NS      1000000
`define PRESCALE_W        17
`define STRAP_CYCLES      3'd4

// ==========================================================
// reset values and fixed codes
`define SETTLE_RESET_MS   16'd750
`define ADDR_STRAP_CLOSED 7'h12
`define ADDR_STRAP_OPEN   7'h13
`define PART_ID           8'h5a
`define FW_MAJOR          8'h01
`define FW_MINOR          8'h00
`define LOG_DEPTH         10

`endif

/* File: verilog/motion_event_monitor_pkg.sv */
// types shared by the motion event monitor and its link port
package motion_event_monitor_pkg;
`include "motion_event_monitor_cfg.svh"

    // ==========================================================
    // link commands, coded in list order from zero
    typedef enum logic [4:0] {
        probe, part_id_read, firmware_revision_read, status_read,
        clear_event_flags, settle_time_write, settle_time_read,
        alert_on, alert_off, alert_config_default,
        bus_address_write, bus_address_read,
        arrival_log_status, arrival_log_age, arrival_log_pop,
        arrival_since_last,
        departure_log_status, departure_log_age, departure_log_pop,
        departure_since_last
    } cmd_e;

    // ==========================================================
    // state of the core on the system clock
    typedef struct packed {
        logic [2:0]                            motion_sync;
        logic [2:0]                            strap_sync;
        logic [2:0]                            alert_sync;
        logic [2:0]                            req_sync;
        logic [2:0]                            strap_cnt;
        logic                                  raw;
        logic                                  deb;
        logic [15:0]                           settle_cnt;
        logic [`PRESCALE_W-1:0]                prescale;
        logic [31:0]                           ms_now;
        logic [15:0]                           settle;
        logic                                  arrival;
        logic                                  departure;
        logic                                  pending;
        logic                                  alert_en;
        logic                                  alert_oe_n;
        logic [6:0]                            bus_addr;
        logic [1:0][31:0]                      last;
        logic [1:0][`LOG_DEPTH-1:0][31:0]      mem;
        logic [1:0][3:0]                       head;
        logic [1:0][3:0]                       cnt;
        logic [31:0]                           rdata;
        logic                                  ack;
        logic                                  ack_tgl;
    } core_s;

    // ==========================================================
    // state of the link port on the link clock
    typedef struct packed {
        logic        busy;
        logic        req_tgl;
        logic [6:0]  addr;
        logic [4:0]  cmd;
        logic [15:0] wdata;
        logic [2:0]  ack_sync;
        logic        done;
        logic        ack;
        logic [31:0] rdata;
    } link_s;

endpackage

/* File: verilog/link_port.sv */
// link-clock side: takes one request, hands it to the core, returns answer
`timescale 1ns/1ps
module link_port
    import motion_event_monitor_pkg::*;
(
    input  wire logic        link_clk,
    input  wire logic        link_reset_n,
    input  wire logic        link_req,
    input  wire logic [6:0]  link_dev_addr,
    input  wire logic [4:0]  link_cmd,
    input  wire logic [15:0] link_wdata,
    output logic             link_busy,
    output logic             link_done,
    output logic             link_ack,
    output logic [31:0]      link_rdata,
    output logic             req_tgl,
    output logic [6:0]       hold_addr,
    output logic [4:0]       hold_cmd,
    output logic [15:0]      hold_wdata,
    input  wire logic        ack_tgl,
    input  wire logic        core_ack,
    input  wire logic [31:0] core_rdata
);

    link_s s;
    link_s next_s;

    // ==========================================================
    // request capture and answer return
    // hold registers stay frozen while busy, so the core may read them
    // as plain words once the toggle has crossed
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.ack_sync = {s.ack_sync[1:0], ack_tgl};
        if (s.busy && (s.ack_sync[1] != s.ack_sync[2])) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.ack = core_ack;
            next_s.rdata = core_rdata;
        end else if (!s.busy && link_req) begin
            next_s.busy = 1'b1;
            next_s.req_tgl = ~s.req_tgl;
            next_s.addr = link_dev_addr;
            next_s.cmd = link_cmd;
            next_s.wdata = link_wdata;
        end
        if (!link_reset_n) begin
            next_s = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        s <= next_s;
    end

    assign link_busy  = s.busy;
    assign link_done  = s.done;
    assign link_ack   = s.ack;
    assign link_rdata = s.rdata;
    assign req_tgl    = s.req_tgl;
    assign hold_addr  = s.addr;
    assign hold_cmd   = s.cmd;
    assign hold_wdata = s.wdata;

endmodule

/* File: bench/host_model.sv */
// host side model: issues link requests and watches the alert wire
`timescale 1ns/1ps
module host_model (
    input  wire logic        link_clk,
    output logic             req,
    output logic [6:0]       addr,
    output logic [4:0]       cmd,
    output logic [15:0]      wdata,
    input  wire logic        busy,
    input  wire logic        done,
    input  wire logic        ack,
    input  wire logic [31:0] rdata,
    input  wire logic        alert_oe_n,
    output logic             alert_wire,
    output int               falls
);
    // pull-up holds the wire high unless the device sinks it
    assign alert_wire = alert_oe_n ? 1'b1 : 1'b0;
    initial begin
        req = 1'b0;
        falls = 0;
    end
    // only the falling edge counts as an alert
    always @(negedge alert_wire) falls++;
    // one request at a time, held until taken, answer read on done
    task automatic xfer(input logic [6:0] a, input logic [4:0] c,
                        input logic [15:0] d, output logic k,
                        output logic [31:0] r);
        int i;
        @(posedge link_clk);
        req <= 1'b1;
        addr <= a;
        cmd <= c;
        wdata <= d;
        do @(posedge link_clk); while (busy);
        // released address and data lines show junk, not the last value
        req <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge link_clk);
        // an answer that never comes must fail every check made on it
        k = (done === 1'b1) ? ack : 1'bx;
        r = (done === 1'b1) ? rdata : 'x;
    endtask
endmodule

/* File: bench/motion_event_monitor_test.sv */
// self-checking bench of the motion event monitor
`timescale 1ns/1ps
`include "motion_event_monitor_cfg.svh"
module motion_event_monitor_test
    import motion_event_monitor_pkg::*;
;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        motion = 1'b0;
    logic        strap = 1'b0;
    logic        alert_o;
    logic        req, busy, done, ack, k, alert_w, oe_n, raw, arr, dep, pend;
    logic [6:0]  dev_addr;
    logic [6:0]  cur = 7'h12;
    logic [4:0]  cmd;
    logic [15:0] wdata;
    logic [31:0] rdata, rd;
    logic [31:0] lfsr = 32'h1053;
    int          errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          falls, s, la, ld, n;
    int          arr_q[$], dep_q[$];

    always #5 clk = ~clk;
    // link clock offset so the two never line up
    initial begin
        #2;
        forever #32 link_clk = ~link_clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    motion_event_monitor #(.MS_CYCLES(10)) i_motion_event_monitor (
        .CLK(clk), .RESET_N(reset_n), .LINK_CLK(link_clk),
        .LINK_RESET_N(reset_n), .MOTION_IN(motion), .ADDR_STRAP_OPEN(strap),
        .ALERT_I(alert_w), .ALERT_O(alert_o), .ALERT_OE_N(oe_n),
        .RAW_MOTION_LEVEL(raw), .ARRIVAL_FLAG(arr), .DEPARTURE_FLAG(dep),
        .EVENT_PENDING_FLAG(pend), .LINK_REQ(req), .LINK_DEV_ADDR(dev_addr),
        .LINK_CMD(cmd), .LINK_WDATA(wdata), .LINK_BUSY(busy),
        .LINK_DONE(done), .LINK_ACK(ack), .LINK_RDATA(rdata));
    host_model i_host_model (
        .link_clk(link_clk), .req(req), .addr(dev_addr), .cmd(cmd),
        .wdata(wdata), .busy(busy), .done(done), .ack(ack), .rdata(rdata),
        .alert_oe_n(oe_n), .alert_wire(alert_w), .falls(falls));

    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // millisecond figures drift by link latency, so allow a few ms
    task automatic near(input string nm, input logic [31:0] v, input int e);
        check(nm, 32'(v + 6 >= e && v <= e + 6), 32'h1);
    endtask
    task automatic conclude;
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t(input cmd_e c, input logic [15:0] d);
        i_host_model.xfer(cur, c, d, k, rd);
        check("ack", k, 1'b1);
    endtask
    // set the sensor, then let the settle window run out; log model
    task automatic motion_to(input logic v);
        int e;
        @(posedge clk);
        motion <= v;
        e = (cyc - 21) / 10 + s;
        if (v)
            la = e;
        else
            ld = e;
        if (v && arr_q.size() < `LOG_DEPTH) arr_q.push_back(e);
        if (!v && dep_q.size() < `LOG_DEPTH) dep_q.push_back(e);
        repeat ((s + 3) * 10) @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        t(part_id_read, 16'h0);
        check("id", rd, 32'(`PART_ID));
        t(firmware_revision_read, 16'h0);
        check("fw", rd, {`FW_MAJOR, `FW_MINOR});
        t(settle_time_read, 16'h0);
        check("settle", rd, 32'(`SETTLE_RESET_MS));
        t(bus_address_read, 16'h0);
        check("addr", rd, 32'(`ADDR_STRAP_CLOSED));
        t(arrival_log_status, 16'h0);
        check("empty", rd, 32'h1);
        i_host_model.xfer(7'h55, probe, 16'h0, k, rd);
        check("stray", k, 1'b0);
        check("stray data", rd, 32'h0);
        lfsr = step(lfsr);
        s = 2 + int'(lfsr % 3);
        t(settle_time_write, 16'(s));
        t(settle_time_read, 16'h0);
        check("settle", rd, s);
        t(alert_on, 16'h0);
        repeat (100) @(posedge clk); // token warm-up, sensor model is clean
        // eleven event pairs overfill both logs by one
        repeat (11) begin
            motion_to(1'b1);
            check("raw", raw, 1'b1);
            check("arr", {arr, pend, oe_n}, 3'b110);
            check("pin low", alert_o, 1'b0);
            t(status_read, 16'h0);
            check("status", rd, 32'h1d);
            t(clear_event_flags, 16'h0);
            check("clear", {arr, dep, pend, oe_n}, 4'b0001);
            motion_to(1'b0);
            check("dep", {dep, oe_n, raw}, 3'b100);
            t(clear_event_flags, 16'h0);
        end
        check("alerts", falls, 22);
        t(arrival_log_status, 16'h0);
        check("afull", rd, 32'h2);
        t(departure_log_status, 16'h0);
        check("dfull", rd, 32'h2);
        n = cyc;
        t(arrival_since_last, 16'h0);
        near("since", rd, (n - 21) / 10 - la);
        n = cyc;
        t(departure_since_last, 16'h0);
        near("dsince", rd, (n - 21) / 10 - ld);
        while (arr_q.size() > 0) begin
            n = cyc;
            t(arrival_log_age, 16'h0);
            near("age", rd, (n - 21) / 10 - arr_q[0]);
            n = cyc;
            t(departure_log_age, 16'h0);
            near("dage", rd, (n - 21) / 10 - dep_q[0]);
            t(arrival_log_pop, 16'h0);
            near("apop", rd, arr_q.pop_front());
            t(departure_log_pop, 16'h0);
            near("dpop", rd, dep_q.pop_front());
        end
        t(departure_log_status, 16'h0);
        check("dempty", rd, 32'h1);
        t(alert_config_default, 16'h0);
        motion_to(1'b1);
        check("quiet", {arr, oe_n}, 2'b11);
        t(alert_on, 16'h0);
        t(alert_off, 16'h0);
        motion_to(1'b0);
        check("off", {dep, oe_n}, 2'b11);
        check("nofall", falls, 22);
        t(bus_address_write, 16'h0021);
        cur = 7'h21;
        t(bus_address_read, 16'h0);
        check("newaddr", rd, 32'h21);
        // a second reset with the strap open comes up on the other address
        @(posedge clk);
        strap <= 1'b1;
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        cur = 7'h13;
        t(bus_address_read, 16'h0);
        check("strap", rd, 32'(`ADDR_STRAP_OPEN));
        t(settle_time_read, 16'h0);
        check("settle2", rd, 32'(`SETTLE_RESET_MS));
        conclude();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
